/* File: hdl/ipcd_defs.svh */
`ifndef IPCD_DEFS_SVH
`define IPCD_DEFS_SVH
// select codes in the five top bits of a configuration word
`define IPCD_UNI_CODE 5'h11
`define IPCD_BIP_CODE 5'h12
// field positions within the 16-bit word
`define IPCD_WORD_BITS 16
`define IPCD_SEL_MSB 15
`define IPCD_SEL_LSB 11
`define IPCD_PAIR_MSB 10
`define IPCD_PAIR_LSB 3
`define IPCD_COM_BIT 2
// reset values
`define IPCD_PAIR_RST 8'h00
`define IPCD_COM_RST 1'b0
`define IPCD_CNT_RST 5'h00
// shared negative-reference input channel; bit count at the last bit of a frame
`define IPCD_SHARED_CH 4'hf
`define IPCD_LAST_BIT 5'h0f
`endif

/* File: hdl/ipcd_pkg.sv */
package ipcd_pkg;
    // how the negative side of the converter is fed
    typedef enum logic [1:0] {
        IPCD_NEG_GND,
        IPCD_NEG_PARTNER,
        IPCD_NEG_SHARED
    } ipcd_neg_e;
    // serial frame state
    typedef enum logic [1:0] {
        IPCD_IDLE,
        IPCD_SHIFT,
        IPCD_HOLD
    } ipcd_frame_e;
endpackage

/* File: hdl/ipcd_dec_if.sv */
`timescale 1ns/100ps
interface ipcd_dec_if;
    logic [7:0] uni;
    logic [7:0] bip;
    logic com;
    logic [3:0] sel;
    logic [3:0] pos;
    logic [3:0] neg;
    ipcd_pkg::ipcd_neg_e kind;
    logic twos;
    modport ctl (output uni, bip, com, sel, input pos, neg, kind, twos);
    modport dec (input uni, bip, com, sel, output pos, neg, kind, twos);
endinterface

/* File: hdl/ipcd_decoder.sv */
`timescale 1ns/100ps
`include "ipcd_defs.svh"
module ipcd_decoder (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // configuration in, selection out
    ipcd_dec_if.dec dif
);

    ////////////////////////////////////////////////////////////////////////
    // pick the pair bit that belongs to a channel
    function automatic logic pair_pick(input logic [7:0] f,
                                       input logic [3:0] s);
        pair_pick = f[3'h7 - s[3:1]];
    endfunction

    logic u_bit;
    logic b_bit;
    logic use_com;
    logic pair_diff;
    logic [3:0] even_ch;
    logic [3:0] pos_d;
    logic [3:0] neg_d;
    ipcd_pkg::ipcd_neg_e kind_d;
    logic twos_d;
    logic [3:0] pos_q;
    logic [3:0] neg_q;
    ipcd_pkg::ipcd_neg_e kind_q;
    logic twos_q;

    // per-channel decode of the pair and common settings
    assign u_bit = pair_pick(dif.uni, dif.sel); // RQ2
    assign b_bit = pair_pick(dif.bip, dif.sel);
    assign use_com = dif.com && (dif.sel != `IPCD_SHARED_CH); // RQ4
    assign pair_diff = u_bit | b_bit;
    assign even_ch = {dif.sel[3:1], 1'b0};
    assign pos_d = (use_com || !pair_diff) ? dif.sel : even_ch; // RQ3
    assign neg_d = use_com ? `IPCD_SHARED_CH
                 : (pair_diff ? {dif.sel[3:1], 1'b1} : 4'h0); // RQ5
    assign kind_d = use_com ? ipcd_pkg::IPCD_NEG_SHARED
                  : (pair_diff ? ipcd_pkg::IPCD_NEG_PARTNER
                               : ipcd_pkg::IPCD_NEG_GND); // RQ7
    // unipolar bit wins over bipolar; common mode forces binary
    assign twos_d = !use_com && !u_bit && b_bit; // RQ6 RQ8

    // registered selection outputs
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pos_q <= 4'h0;
            neg_q <= 4'h0;
            kind_q <= ipcd_pkg::IPCD_NEG_GND;
            twos_q <= 1'b0;
        end else begin
            pos_q <= pos_d;
            neg_q <= neg_d;
            kind_q <= kind_d;
            twos_q <= twos_d;
        end
    end

    assign dif.pos = pos_q;
    assign dif.neg = neg_q;
    assign dif.kind = kind_q;
    assign dif.twos = twos_q;

    ////////////////////////////////////////////////////////////////////////
    // checks on the decode
    a_single_ended_binary: assert property ( // RQ3
        @(posedge ref_clk) disable iff (!nrst)
        (!use_com && !u_bit && !b_bit) |=> (kind_q == ipcd_pkg::IPCD_NEG_GND
            && pos_q == $past(dif.sel) && !twos_q))
        else $error("single-ended channel decoded wrongly");

    a_common_ref_mode: assert property ( // RQ4
        @(posedge ref_clk) disable iff (!nrst)
        (dif.com && dif.sel != 4'hf) |=> (kind_q == ipcd_pkg::IPCD_NEG_SHARED
            && neg_q == 4'hf && pos_q == $past(dif.sel)))
        else $error("common reference mode not applied");

    a_common_ignores_pair: assert property ( // RQ5
        @(posedge ref_clk) disable iff (!nrst)
        (use_com && (u_bit || b_bit)) |=> !twos_q
            && kind_q != ipcd_pkg::IPCD_NEG_PARTNER)
        else $error("pair bits leaked into common mode");

    a_bipolar_pair: assert property ( // RQ6
        @(posedge ref_clk) disable iff (!nrst)
        (!use_com && !u_bit && b_bit) |=> (twos_q
            && kind_q == ipcd_pkg::IPCD_NEG_PARTNER
            && pos_q == {$past(dif.sel[3:1]), 1'b0}
            && neg_q == {$past(dif.sel[3:1]), 1'b1}))
        else $error("bipolar pair not twos complement");

    a_unipolar_pair: assert property ( // RQ7
        @(posedge ref_clk) disable iff (!nrst)
        (!use_com && u_bit) |=> (!twos_q
            && kind_q == ipcd_pkg::IPCD_NEG_PARTNER
            && pos_q[0] == 1'b0 && neg_q[0] == 1'b1))
        else $error("unipolar pair not binary differential");

    a_unipolar_wins: assert property ( // RQ8
        @(posedge ref_clk) disable iff (!nrst)
        (!use_com && u_bit && b_bit) |=> !twos_q)
        else $error("bipolar bit overrode unipolar bit");

endmodule

/* File: hdl/ipcd_top.sv */
`timescale 1ns/100ps
`include "ipcd_defs.svh"
// Overview of operation
// RQ1: word with top five bits 10001 writes the unipolar register.
// RQ2: unipolar bits 10..3 map pairs 0/1..14/15; set = pseudo-differential.
// RQ3: both pair bits zero: selected channel alone, single-ended, binary.
// RQ4: unipolar bit 2 enables common reference; inputs 0..14 use input 15.
// RQ5: common mode converts selected channel against input 15, binary.
// RQ6: bipolar bit only: pair converted differentially, twos complement.
// RQ7: unipolar bit set: pair converted differentially, straight binary.
// RQ8: both bits set: unipolar wins, straight binary.
// RQ9: host sets bipolar bit and clears unipolar bit for bipolar pairs.
// RQ10: top bits 10010 write the bipolar register, bits 10..3 per pair.
// RQ11: host sets word MSB for configuration writes, clears it for mode.
// RQ12: two lowest unipolar bits ignored; pair and common bits reset to zero.
module ipcd_top (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // serial port, synchronous to ref_clk
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    // channel chosen by the mode logic
    input wire logic [3:0] channel_select_field,
    // stored configuration
    output logic [7:0] pair_pseudo_diff_bit,
    output logic [7:0] pair_bipolar_bit,
    output logic common_reference_enable,
    // converter input selection
    output logic [3:0] conv_pos_ch,
    output logic [3:0] conv_neg_ch,
    output ipcd_pkg::ipcd_neg_e conv_neg_kind,
    output logic conv_twos_comp
);

    ////////////////////////////////////////////////////////////////////////
    // serial frame receiver
    ipcd_pkg::ipcd_frame_e state_q;
    ipcd_pkg::ipcd_frame_e state_d;
    logic sclk_prev_q;
    logic [4:0] bit_cnt_q;
    logic [4:0] bit_cnt_d;
    logic [15:0] shift_q;
    logic [15:0] shift_d;
    logic [15:0] word_w;
    logic sclk_rise;
    logic last_bit;
    logic commit;
    logic [4:0] sel_code;
    logic uni_wr;
    logic bip_wr;
    logic [7:0] uni_q;
    logic [7:0] bip_q;
    logic com_q;

    // edge detect and the word as it would stand after this bit
    assign sclk_rise = sclk && !sclk_prev_q && !cs_n;
    assign word_w = {shift_q[14:0], din};
    assign last_bit = sclk_rise && (bit_cnt_q == `IPCD_LAST_BIT);
    assign commit = (state_q == ipcd_pkg::IPCD_SHIFT) && last_bit;
    assign sel_code = word_w[`IPCD_SEL_MSB:`IPCD_SEL_LSB];
    // MSB low is a mode instruction and matches neither code
    assign uni_wr = commit && (sel_code == `IPCD_UNI_CODE); // RQ1 RQ11
    assign bip_wr = commit && (sel_code == `IPCD_BIP_CODE); // RQ10

    // frame sequencing: shift 16 bits, then hold until select rises
    always_comb begin
        state_d = state_q;
        bit_cnt_d = bit_cnt_q;
        shift_d = shift_q;
        case (state_q)
            ipcd_pkg::IPCD_IDLE: begin
                bit_cnt_d = `IPCD_CNT_RST;
                if (!cs_n) begin
                    state_d = ipcd_pkg::IPCD_SHIFT;
                end
                if (sclk_rise) begin
                    shift_d = word_w;
                    bit_cnt_d = 5'h01;
                end
            end
            ipcd_pkg::IPCD_SHIFT: begin
                if (cs_n) begin
                    state_d = ipcd_pkg::IPCD_IDLE;
                    bit_cnt_d = `IPCD_CNT_RST;
                end else if (sclk_rise) begin
                    shift_d = word_w;
                    bit_cnt_d = bit_cnt_q + 5'h01;
                    if (last_bit) begin
                        state_d = ipcd_pkg::IPCD_HOLD;
                    end
                end
            end
            ipcd_pkg::IPCD_HOLD: begin
                if (cs_n) begin
                    state_d = ipcd_pkg::IPCD_IDLE;
                    bit_cnt_d = `IPCD_CNT_RST;
                end
            end
            default: begin
                state_d = ipcd_pkg::IPCD_IDLE;
                bit_cnt_d = `IPCD_CNT_RST;
            end
        endcase
    end

    // receiver flops
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= ipcd_pkg::IPCD_IDLE;
            sclk_prev_q <= 1'b0;
            bit_cnt_q <= `IPCD_CNT_RST;
            shift_q <= 16'h0000;
        end else begin
            state_q <= state_d;
            sclk_prev_q <= sclk;
            bit_cnt_q <= bit_cnt_d;
            shift_q <= shift_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration registers; low two unipolar bits are dropped
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            uni_q <= `IPCD_PAIR_RST; // RQ12
            bip_q <= `IPCD_PAIR_RST;
            com_q <= `IPCD_COM_RST; // RQ12
        end else begin
            if (uni_wr) begin
                uni_q <= word_w[`IPCD_PAIR_MSB:`IPCD_PAIR_LSB]; // RQ2
                com_q <= word_w[`IPCD_COM_BIT]; // RQ4
            end
            if (bip_wr) begin
                bip_q <= word_w[`IPCD_PAIR_MSB:`IPCD_PAIR_LSB]; // RQ10
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // channel decode
    ipcd_dec_if dif ();

    assign dif.uni = uni_q;
    assign dif.bip = bip_q;
    assign dif.com = com_q;
    assign dif.sel = channel_select_field;

    ipcd_decoder u_dec (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .dif(dif)
    );

    // outputs straight from flops
    assign pair_pseudo_diff_bit = uni_q;
    assign pair_bipolar_bit = bip_q;
    assign common_reference_enable = com_q;
    assign conv_pos_ch = dif.pos;
    assign conv_neg_ch = dif.neg;
    assign conv_neg_kind = dif.kind;
    assign conv_twos_comp = dif.twos;

    ////////////////////////////////////////////////////////////////////////
    // checks on the register writes
    // rises seen in the current frame, counted apart from the receiver
    logic [4:0] frame_rises_q;

    // saturating rise count, cleared while the frame is closed
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            frame_rises_q <= `IPCD_CNT_RST;
        end else if (cs_n) begin
            frame_rises_q <= `IPCD_CNT_RST;
        end else if (sclk && !sclk_prev_q && frame_rises_q != 5'h1f) begin
            frame_rises_q <= frame_rises_q + 5'h01;
        end
    end

    a_uni_write_load: assert property ( // RQ1
        @(posedge ref_clk) disable iff (!nrst)
        (commit && word_w[15:11] == 5'b10001) |=>
            (uni_q == $past(word_w[10:3]) && com_q == $past(word_w[2])))
        else $error("unipolar word not loaded");

    a_uni_other_kept: assert property ( // RQ1
        @(posedge ref_clk) disable iff (!nrst)
        (!(commit && word_w[15:11] == 5'b10001)) |=>
            ($stable(uni_q) && $stable(com_q)))
        else $error("unipolar register changed without its code");

    a_pair_bit_order: assert property ( // RQ2
        @(posedge ref_clk) disable iff (!nrst)
        uni_wr |=> (pair_pseudo_diff_bit[7] == $past(word_w[10])
            && pair_pseudo_diff_bit[0] == $past(word_w[3])))
        else $error("pair bit order wrong");

    a_bip_write_load: assert property ( // RQ10
        @(posedge ref_clk) disable iff (!nrst)
        (commit && word_w[15:11] == 5'b10010) |=>
            (bip_q == $past(word_w[10:3]) && $stable(uni_q)))
        else $error("bipolar word not loaded");

    a_reset_clear: assert property ( // RQ12
        @(posedge ref_clk) disable iff (!nrst)
        $rose(nrst) |-> (uni_q == 8'h00 && com_q == 1'b0))
        else $error("config not clear after reset");

    a_sixteen_bits: assert property ( // RQ1
        @(posedge ref_clk) disable iff (!nrst)
        commit == (sclk && !sclk_prev_q && !cs_n && frame_rises_q == 5'h0f))
        else $error("word committed at wrong bit");

    a_bip_other_kept: assert property ( // RQ10
        @(posedge ref_clk) disable iff (!nrst)
        (!(commit && word_w[15:11] == 5'b10010)) |=>
            $stable(bip_q))
        else $error("bipolar register changed without its code");

    a_cut_frame_dropped: assert property ( // RQ1
        @(posedge ref_clk) disable iff (!nrst)
        cs_n |=>
            (bit_cnt_q == `IPCD_CNT_RST))
        else $error("bit count kept across a closed frame");

endmodule

/* File: verif/ipcd_host_model.sv */
`timescale 1ns/100ps
module ipcd_host_model (
    // clock
    input wire logic ref_clk,
    // serial port toward the device
    output logic sclk,
    output logic cs_n,
    output logic din
);
    // idle: frame closed, serial clock parked low
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    // one frame, msb first; fewer than 16 bits aborts the word
    task automatic send_word(input logic [15:0] w, input int nbits);
        int i;
        @(negedge ref_clk);
        cs_n = 1'b0;
        for (i = 15; i > 15 - nbits; i--) begin
            @(negedge ref_clk);
            sclk = 1'b1;
            din = w[i];
            @(negedge ref_clk);
            sclk = 1'b0;
        end
        @(negedge ref_clk);
        cs_n = 1'b1;
        din = ~din; // last bit inverted, no stale bit
    endtask
endmodule

/* File: verif/input_pairing_coding_decode_test.sv */
`timescale 1ns/100ps
module input_pairing_coding_decode_test;
    logic ref_clk;
    logic nrst;
    logic sclk;
    logic cs_n;
    logic din;
    logic [3:0] chan;
    logic [7:0] uni_bits;
    logic [7:0] bip_bits;
    logic com_en;
    logic [3:0] pos_ch;
    logic [3:0] neg_ch;
    ipcd_pkg::ipcd_neg_e neg_kind;
    logic twos;
    int mismatches;
    int n_checks;
    int cycles;
    int p;
    ////////////////////////////////////////////////////////////////////////
    // 100 MHz clock
    initial ref_clk = 1'b0;
    always #5 ref_clk = ~ref_clk;

    // design and host
    ipcd_top dut (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .sclk(sclk),
        .cs_n(cs_n),
        .din(din),
        .channel_select_field(chan),
        .pair_pseudo_diff_bit(uni_bits),
        .pair_bipolar_bit(bip_bits),
        .common_reference_enable(com_en),
        .conv_pos_ch(pos_ch),
        .conv_neg_ch(neg_ch),
        .conv_neg_kind(neg_kind),
        .conv_twos_comp(twos)
    );
    ipcd_host_model host (
        .ref_clk(ref_clk),
        .sclk(sclk),
        .cs_n(cs_n),
        .din(din)
    );
    ////////////////////////////////////////////////////////////////////////
    // verdict and end of run
    task stop_test;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // one comparison
    task chk(input string what, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask

    // frame, then let registers and decode settle
    task wr(input logic [15:0] w, input int n);
        host.send_word(w, n);
        repeat (3) @(negedge ref_clk);
    endtask

    // select a channel, compare the decode two cycles later
    task conv(input logic [3:0] ch, input logic [3:0] ep,
              input logic [3:0] en, input logic [1:0] ek, input logic et);
        @(negedge ref_clk);
        chan = ch;
        repeat (2) @(negedge ref_clk);
        chk("conv", {1'b0, ch, ep, en, ek, et},
            {1'b0, ch, pos_ch, neg_ch, neg_kind, twos});
    endtask
    ////////////////////////////////////////////////////////////////////////
    // hang guard
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            stop_test();
        end
    end

    // main sequence
    initial begin
        nrst = 1'b0;
        chan = 4'h0;
        cycles = 0;
        mismatches = 0;
        n_checks = 0;
        repeat (16) @(negedge ref_clk);
        nrst = 1'b1;
        @(negedge ref_clk);
        chk("cfg", 16'h0000, {7'h00, uni_bits, com_en});
        chk("bip", 16'h0000, {8'h00, bip_bits});
        conv(4'h3, 4'h3, 4'h0, ipcd_pkg::IPCD_NEG_GND, 1'b0);
        // bipolar pair 0/1 while its unipolar bit is clear
        wr({5'h12, 8'h80, 3'h0}, 16);
        chk("bip", {8'h00, 8'h80}, {8'h00, bip_bits});
        conv(4'h1, 4'h0, 4'h1, ipcd_pkg::IPCD_NEG_PARTNER, 1'b1);
        conv(4'h0, 4'h0, 4'h1, ipcd_pkg::IPCD_NEG_PARTNER, 1'b1);
        conv(4'h2, 4'h2, 4'h0, ipcd_pkg::IPCD_NEG_GND, 1'b0);
        // unipolar pairs 0/1 and 2/3, low bits set
        wr({5'h11, 8'hc0, 3'h3}, 16);
        chk("cfg", {7'h00, 8'hc0, 1'b0}, {7'h00, uni_bits, com_en});
        conv(4'h0, 4'h0, 4'h1, ipcd_pkg::IPCD_NEG_PARTNER, 1'b0);
        conv(4'h3, 4'h2, 4'h3, ipcd_pkg::IPCD_NEG_PARTNER, 1'b0);
        // mode word and truncated frame leave config alone
        wr({5'h01, 8'h00, 3'h4}, 16);
        wr({5'h11, 8'h00, 3'h4}, 15);
        chk("cfg", {7'h00, 8'hc0, 1'b0}, {7'h00, uni_bits, com_en});
        // common reference mode
        wr({5'h11, 8'hc0, 3'h4}, 16);
        chk("com", 16'h0001, {15'h0000, com_en});
        conv(4'h1, 4'h1, 4'hf, ipcd_pkg::IPCD_NEG_SHARED, 1'b0);
        conv(4'he, 4'he, 4'hf, ipcd_pkg::IPCD_NEG_SHARED, 1'b0);
        conv(4'hf, 4'hf, 4'h0, ipcd_pkg::IPCD_NEG_GND, 1'b0);
        // each pair bit alone, common mode cleared
        for (p = 0; p < 8; p++) begin
            wr({5'h11, 8'h80 >> p, 3'h0}, 16);
            conv(4'(2 * p + 1), 4'(2 * p), 4'(2 * p + 1),
                 ipcd_pkg::IPCD_NEG_PARTNER, 1'b0);
        end
        // reset in mid-run clears both registers
        nrst = 1'b0;
        repeat (2) @(negedge ref_clk);
        nrst = 1'b1;
        @(negedge ref_clk);
        chk("cfg", 16'h0000, {7'h00, uni_bits, com_en});
        chk("bip", 16'h0000, {8'h00, bip_bits});
        conv(4'h1, 4'h1, 4'h0, ipcd_pkg::IPCD_NEG_GND, 1'b0);
        stop_test();
    end
endmodule
